// ==== rtl/aiorc_consts.svh ====
// Purpose: Named offsets, field positions and reset values for the analog routing registers
// Assumes: Avalon-MM byte addresses, 8-bit registers in the low lanes
// Notes: Definitions only
`ifndef AIORC_CONSTS_SVH
`define AIORC_CONSTS_SVH

`define AIORC_OFS_INPUT_SELECT 8'h60
`define AIORC_OFS_OUTBUF_CTRL 8'h62
`define AIORC_RST_INPUT_SELECT 8'h00
`define AIORC_RST_OUTBUF_CTRL 8'h00
`define AIORC_ADDR_W 8
`define AIORC_DATA_W 32
`define AIORC_REG_W 8

`define AIORC_COL3_SEL_HI 7
`define AIORC_COL3_SEL_LO 6
`define AIORC_COL2_SEL_HI 5
`define AIORC_COL2_SEL_LO 4
`define AIORC_COL1_SEL_HI 3
`define AIORC_COL1_SEL_LO 2
`define AIORC_COL0_SEL_HI 1
`define AIORC_COL0_SEL_LO 0

`define AIORC_COL1_SRC_BIT 7
`define AIORC_COL2_SRC_BIT 6
`define AIORC_COL1_BUF_BIT 5
`define AIORC_COL2_BUF_BIT 4
`define AIORC_COL0_BUF_BIT 3
`define AIORC_COL3_BUF_BIT 2
`define AIORC_RSVD_BIT 1
`define AIORC_PWR_BIT 0

`endif

// ==== rtl/aiorc_pkg.sv ====
// Purpose: Types for the analog routing configuration block
// Assumes: Nothing beyond the constants header
// Notes: State of the top module, except the column inputs, is one packed struct
`default_nettype none
package aiorc_pkg;
  typedef struct packed {
    logic [7:0] input_select;
    logic [7:0] outbuf_ctrl;
    logic waitreq;
    logic [31:0] readdata;
    logic [3:0] pin_out;
  } aiorc_state_t;
endpackage : aiorc_pkg
`default_nettype wire

// ==== rtl/aiorc_top.sv ====
// Purpose: Analog input routing and output buffer configuration registers
// Assumes: Avalon-MM slave, one-wait-state answer, synchronous active-low reset
// Notes: Pin choice shown as selected port-0 level per column
//
// Behaviour
// - Input select is 8-bit read/write, resets to zero, four 2-bit column fields.
// - Each column multiplexer picks one of at most four port bits.
// - Bits 7:6 pick column 3 pin from port-0 pins 0, 2, 4, 6.
// - Bits 5:4 pick column 2 pin from port-0 pins 1, 3, 5, 7.
// - Bits 3:2 pick column 1 pin from port-0 pins 0, 2, 4, 6.
// - Bits 1:0 pick column 0 pin from port-0 pins 1, 3, 5, 7.
// - Buffer control bit 7 feeds column 1 from mux 1 when 0, mux 0 when 1.
// - Buffer control bit 6 feeds column 2 from mux 2 when 0, mux 3 when 1.
// - Buffer control is 8-bit write-only, resets to zero, bit 1 reserved.
// - Buffer enables: bit 5 col1, bit 4 col2, bit 3 col0, bit 2 col3.
// - Bit 0 sets shared output buffer power; zero means low power.
`include "aiorc_consts.svh"
`default_nettype none
module aiorc_top
  import aiorc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Port-0 pins feeding the column multiplexers
  input wire logic [7:0] port0_in,
  // Column pin selects
  output logic [1:0] col0_pin_select,
  output logic [1:0] col1_pin_select,
  output logic [1:0] col2_pin_select,
  output logic [1:0] col3_pin_select,
  // Multiplexer outputs and column inputs
  output logic [3:0] col_mux_out,
  output logic [3:0] col_input,
  // Source selects, buffer enables, power
  output logic col1_source_select,
  output logic col2_source_select,
  output logic col0_outbuf_enable,
  output logic col1_outbuf_enable,
  output logic col2_outbuf_enable,
  output logic col3_outbuf_enable,
  output logic outbuf_power_level
);

  aiorc_state_t s_q;
  aiorc_state_t s_d;
  logic [3:0] col_input_q;
  logic [3:0] col_input_d;

  // Odd-pin mux: code n picks pin 2n+1; even-pin mux: code n picks pin 2n
  function automatic logic pin_pick(input logic [7:0] pins, input logic [1:0] code,
                                    input logic odd);
    logic [2:0] idx;
    idx = {code, odd};
    return pins[idx];
  endfunction : pin_pick

  always_comb begin
    logic req;
    logic [7:0] isel;
    logic [7:0] bctl;
    s_d = s_q;
    req = avs_read | avs_write;
    s_d.waitreq = 1'b1;
    isel = s_q.input_select;
    bctl = s_q.outbuf_ctrl;
    // Answer on the second cycle of each request
    if (req && s_q.waitreq) begin
      s_d.waitreq = 1'b0;
      s_d.readdata = '0;
      if (avs_read && avs_address == `AIORC_OFS_INPUT_SELECT) begin
        s_d.readdata = {24'h000000, s_q.input_select};
      end
      // Write-only and unmapped reads give zero
    end
    // Write lands only at the edge where the master sees waitrequest low
    if (avs_write && !s_q.waitreq && avs_byteenable[0]) begin
      if (avs_address == `AIORC_OFS_INPUT_SELECT) begin
        isel = avs_writedata[`AIORC_REG_W-1:0];
      end else if (avs_address == `AIORC_OFS_OUTBUF_CTRL) begin
        bctl = avs_writedata[`AIORC_REG_W-1:0];
        bctl[`AIORC_RSVD_BIT] = 1'b0;
      end
    end
    s_d.input_select = isel;
    s_d.outbuf_ctrl = bctl;
    // Each mux sees four port bits only
    s_d.pin_out[3] = pin_pick(port0_in, isel[`AIORC_COL3_SEL_HI:`AIORC_COL3_SEL_LO],
                              1'b0);
    s_d.pin_out[2] = pin_pick(port0_in, isel[`AIORC_COL2_SEL_HI:`AIORC_COL2_SEL_LO],
                              1'b1);
    s_d.pin_out[1] = pin_pick(port0_in, isel[`AIORC_COL1_SEL_HI:`AIORC_COL1_SEL_LO],
                              1'b0);
    s_d.pin_out[0] = pin_pick(port0_in, isel[`AIORC_COL0_SEL_HI:`AIORC_COL0_SEL_LO],
                              1'b1);
    col_input_d[0] = s_d.pin_out[0];
    col_input_d[3] = s_d.pin_out[3];
    col_input_d[1] = bctl[`AIORC_COL1_SRC_BIT] ? s_d.pin_out[0] : s_d.pin_out[1];
    col_input_d[2] = bctl[`AIORC_COL2_SRC_BIT] ? s_d.pin_out[3] : s_d.pin_out[2];
    if (!nrst) begin
      s_d = '0;
      s_d.input_select = `AIORC_RST_INPUT_SELECT;
      s_d.outbuf_ctrl = `AIORC_RST_OUTBUF_CTRL;
      s_d.waitreq = 1'b1;
      col_input_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
    col_input_q <= col_input_d;
  end

  assign avs_readdata = s_q.readdata;
  assign avs_waitrequest = s_q.waitreq;
  assign col3_pin_select = s_q.input_select[`AIORC_COL3_SEL_HI:`AIORC_COL3_SEL_LO];
  assign col2_pin_select = s_q.input_select[`AIORC_COL2_SEL_HI:`AIORC_COL2_SEL_LO];
  assign col1_pin_select = s_q.input_select[`AIORC_COL1_SEL_HI:`AIORC_COL1_SEL_LO];
  assign col0_pin_select = s_q.input_select[`AIORC_COL0_SEL_HI:`AIORC_COL0_SEL_LO];
  assign col_mux_out = s_q.pin_out;
  assign col_input = col_input_q;
  assign col1_source_select = s_q.outbuf_ctrl[`AIORC_COL1_SRC_BIT];
  assign col2_source_select = s_q.outbuf_ctrl[`AIORC_COL2_SRC_BIT];
  assign col1_outbuf_enable = s_q.outbuf_ctrl[`AIORC_COL1_BUF_BIT];
  assign col2_outbuf_enable = s_q.outbuf_ctrl[`AIORC_COL2_BUF_BIT];
  assign col0_outbuf_enable = s_q.outbuf_ctrl[`AIORC_COL0_BUF_BIT];
  assign col3_outbuf_enable = s_q.outbuf_ctrl[`AIORC_COL3_BUF_BIT];
  assign outbuf_power_level = s_q.outbuf_ctrl[`AIORC_PWR_BIT];

endmodule : aiorc_top
`default_nettype wire

// ==== bench/aiorc_sva.sv ====
// Purpose: Port assertions for the analog routing registers
// Assumes: One clock, nrst synchronous active low
// Notes: Bound from the testbench file
`default_nettype none
module aiorc_sva (
  // Clock, reset, bus, port-0 pins, mux outputs and column inputs
  input wire logic clk, nrst, avs_read, avs_write, avs_waitrequest,
  input wire logic [7:0] avs_address, port0_in,
  input wire logic [31:0] avs_writedata, avs_readdata,
  input wire logic [3:0] avs_byteenable, col_mux_out, col_input,
  // Routing controls
  input wire logic [1:0] col0_pin_select, col1_pin_select, col2_pin_select, col3_pin_select,
  input wire logic col1_source_select, col2_source_select, col0_outbuf_enable,
  input wire logic col1_outbuf_enable, col2_outbuf_enable, col3_outbuf_enable, outbuf_power_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] p0_q;
  logic [7:0] sel;
  logic [6:0] ctl;
  always_ff @(posedge clk) p0_q <= port0_in;
  assign sel = {col3_pin_select, col2_pin_select, col1_pin_select, col0_pin_select};
  assign ctl = {col1_source_select, col2_source_select, col1_outbuf_enable,
                col2_outbuf_enable, col0_outbuf_enable, col3_outbuf_enable, outbuf_power_level};
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_wr(a); avs_write && avs_byteenable[0] && !avs_waitrequest && avs_address == a; endsequence
  sequence s_rd(a); avs_read && !avs_waitrequest && avs_address == a; endsequence
  sequence s_answer; !avs_waitrequest ##1 avs_waitrequest; endsequence
  a_insel_write: assert property (s_wr(8'h60) |=> sel == $past(avs_writedata[7:0]))
    else $error("input select write lost");
  a_ctrl_write: assert property (s_wr(8'h62) |=> ctl ==
    {$past(avs_writedata[7:2]), $past(avs_writedata[0])}) else $error("buffer control write lost");
  a_ctrl_rdzero: assert property (s_rd(8'h62) |-> avs_readdata == 32'h0)
    else $error("buffer control read not zero");
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> s_answer)
    else $error("answer not one wait state");
  a_mux_even: assert property ($past(nrst) |-> col_mux_out[1] == p0_q[{col1_pin_select, 1'h0}]
    && col_mux_out[3] == p0_q[{col3_pin_select, 1'h0}]) else $error("even pin mux wrong");
  a_mux_odd: assert property ($past(nrst) |-> col_mux_out[0] == p0_q[{col0_pin_select, 1'h1}]
    && col_mux_out[2] == p0_q[{col2_pin_select, 1'h1}]) else $error("odd pin mux wrong");
  a_col1_route: assert property ($past(nrst) |-> col_input[1] == (col1_source_select ?
    col_mux_out[0] : col_mux_out[1])) else $error("column 1 source wrong");
  a_col2_route: assert property ($past(nrst) |-> col_input[2] == (col2_source_select ?
    col_mux_out[3] : col_mux_out[2])) else $error("column 2 source wrong");
endmodule : aiorc_sva
`default_nettype wire

// ==== bench/testbench.sv ====
// Purpose: Self-checking bench for the analog routing registers
// Assumes: One-wait-state Avalon-MM answer
// Notes: Port-0 levels change only between bus cycles
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, nrst = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
  logic [7:0] avs_address = 8'h00, port0_in = 8'h96, p, ctl;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [3:0] avs_byteenable = 4'hF, col_mux_out, col_input, m;
  logic [1:0] col0_pin_select, col1_pin_select, col2_pin_select, col3_pin_select, a, b;
  logic col1_source_select, col2_source_select, col0_outbuf_enable, col1_outbuf_enable;
  logic col2_outbuf_enable, col3_outbuf_enable, outbuf_power_level;
  int errors = 0, tests_run = 0;
  always #12.5 clk = ~clk;
  aiorc_top i_dut (.*);
  assign ctl = {col1_source_select, col2_source_select, col1_outbuf_enable,
                col2_outbuf_enable, col0_outbuf_enable, col3_outbuf_enable, 1'h0, outbuf_power_level};
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  task automatic bus(input logic w, input logic [7:0] ad, input logic [7:0] d);
    int n = 0;
    @(posedge clk);
    avs_address <= ad;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (n < 9 && avs_waitrequest !== 1'h0);
    if (n == 9) begin
      errors++;
      give_verdict();
    end
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge clk);
  endtask : bus
  task automatic t_reset();
    bus(0, 8'h60, 8'h00);
    chk("input select", 32'h0, q);
    chk("buffer control", 32'h0, {24'h0, ctl});
    $display("reset test done");
  endtask : t_reset
  task automatic t_fields();
    for (int c = 0; c < 4; c++) begin
      a = c[1:0];
      b = ~a;
      p = 8'h96 ^ {8{c[0]}};
      port0_in <= p;
      bus(1, 8'h60, {a, b, b, a});
      bus(0, 8'h60, 8'h00);
      chk("select readback", {24'h0, a, b, b, a}, q);
      chk("pin selects", {24'h0, a, b, b, a}, {24'h0, col3_pin_select, col2_pin_select,
          col1_pin_select, col0_pin_select});
      m = {p[{a, 1'h0}], p[{b, 1'h1}], p[{b, 1'h0}], p[{a, 1'h1}]};
      chk("mux outputs", {28'h0, m}, {28'h0, col_mux_out});
    end
    $display("field test done");
  endtask : t_fields
  task automatic t_ctrl();
    logic [7:0] v[2] = '{8'hC3, 8'h3E};
    foreach (v[i]) begin
      bus(1, 8'h62, v[i]);
      chk("control outputs", {24'h0, v[i] & 8'hFD}, {24'h0, ctl});
      chk("column inputs", {28'h0, m[3], v[i][6] ? m[3] : m[2], v[i][7] ? m[0] : m[1], m[0]},
          {28'h0, col_input});
      bus(0, 8'h62, 8'h00);
      chk("control read", 32'h0, q);
    end
    $display("control test done");
  endtask : t_ctrl
  task automatic t_unmapped();
    bus(1, 8'h61, 8'hFF);
    avs_byteenable <= 4'hE;
    bus(1, 8'h60, 8'h5A);
    avs_byteenable <= 4'hF;
    bus(0, 8'h61, 8'h00);
    chk("unmapped read", 32'h0, q);
    bus(0, 8'h60, 8'h00);
    chk("select kept", {24'h0, a, b, b, a}, q);
    $display("unmapped test done");
  endtask : t_unmapped
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    t_reset();
    t_fields();
    t_ctrl();
    t_unmapped();
    give_verdict();
  end
endmodule : testbench
bind aiorc_top aiorc_sva u_sva (.*);
`default_nettype wire
